// [hw/prcf_cap_if.sv]
// Interface: push, pop and head of the ingress capture buffer
`timescale 1ns/1ps
interface prcf_cap_if;
  logic push;
  prcf_pkg::prcf_capture_s push_entry;
  logic pop;
  prcf_pkg::prcf_capture_s head;
  logic [2:0] count;
  modport buffer (input push, input push_entry, input pop, output head, output count);
  modport user (output push, output push_entry, output pop, input head, input count);
endinterface : prcf_cap_if

// [hw/prcf_capture_buffer.sv]
// Four-entry buffer of ingress captures, each entry written whole
`timescale 1ns/1ps
module prcf_capture_buffer (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  prcf_cap_if.buffer cap
);
  prcf_pkg::prcf_capture_s store [prcf_pkg::CAP_DEPTH];
  prcf_pkg::prcf_capture_s next_store [prcf_pkg::CAP_DEPTH];
  logic [1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [2:0] count, next_count;
  logic do_push, do_pop;

  always_comb begin
    // Full buffer keeps the oldest captures; newer ones are lost
    do_push = cap.push && (count != prcf_pkg::CAP_FULL_COUNT);
    do_pop = cap.pop && (count != 3'h0);
    next_store = store;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (do_push) begin
      next_store[wr_ptr] = cap.push_entry;
      next_wr_ptr = wr_ptr + 2'h1;
    end
    if (do_pop) begin
      next_rd_ptr = rd_ptr + 2'h1;
    end
    next_count = count + {2'h0, do_push} - {2'h0, do_pop};
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < prcf_pkg::CAP_DEPTH; i++) begin
        store[i] <= '0;
      end
      wr_ptr <= 2'h0;
      rd_ptr <= 2'h0;
      count <= 3'h0;
    end else begin
      store <= next_store;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  assign cap.head = store[rd_ptr];
  assign cap.count = count;

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  AST_CAP_BOUND: assert property (count <= prcf_pkg::CAP_FULL_COUNT)
    else $error("capture count above four");
  AST_CAP_FULL_KEEP: assert property (
    (count == prcf_pkg::CAP_FULL_COUNT) && cap.push && !cap.pop
      |=> (count == prcf_pkg::CAP_FULL_COUNT) && $stable(cap.head))
    else $error("full buffer changed on push");
  AST_CAP_ATOMIC: assert property (
    cap.push && (count == 3'h0) |=> cap.head == $past(cap.push_entry))
    else $error("head entry differs from pushed capture");
endmodule : prcf_capture_buffer

// [hw/prcf_pkg.sv]
// Package: offsets, field positions, reset values and types of the receive capture filter
package prcf_pkg;
  localparam logic [11:0] OFS_CF_MOD = 12'h164;
  localparam logic [11:0] OFS_FILTER = 12'h168;
  localparam logic [11:0] OFS_CAP_SEC = 12'h16c;
  localparam logic [11:0] OFS_CAP_NS = 12'h170;
  localparam logic [11:0] OFS_CAP_HDR = 12'h174;
  localparam logic [11:0] OFS_PDREQ_SEC = 12'h178;
  localparam logic [11:0] OFS_PDREQ_NS = 12'h17c;
  localparam logic [11:0] OFS_REFERENCE = 12'h190;
  localparam logic [11:0] OFS_CAP_STATUS = 12'h194;
  localparam logic [11:0] OFS_BANK_SEL = 12'h198;

  localparam logic [15:0] RST_CF_MOD = 16'h000f;
  localparam logic [15:0] RST_TYPE_FILTER = 16'h0000;
  localparam logic [3:0] RST_VERSION_REF = 4'h2;
  localparam logic [7:0] RST_DOMAIN_REF = 8'h00;
  localparam logic [2:0] RST_BANK_SEL = 3'h0;

  localparam int ALT_FLT_BIT = 18;
  localparam int DOM_FLT_BIT = 17;
  localparam int VER_FLT_BIT = 16;
  localparam int AUTO_UPDATE_BIT = 31;
  localparam int POP_BIT = 0;
  localparam int DOMAIN_REF_LSB = 8;

  localparam int CAP_DEPTH = 4;
  localparam logic [2:0] CAP_FULL_COUNT = 3'h4;
  localparam logic [3:0] KIND_PDELAY_REQ = 4'h2;
  localparam logic [3:0] VERSION_ANY = 4'h0;
  localparam logic [2:0] PORT_BANK = 3'h1;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [11:0] source_identity_crc;
    logic [3:0] message_kind_code;
    logic [15:0] sequence_number;
    logic [31:0] capture_whole_seconds;
    logic [29:0] capture_nanos;
  } prcf_capture_s;
endpackage : prcf_pkg

// [hw/prcf_rx_filter.sv]
// Receive capture and filter register bank with AXI4-Lite slave
`timescale 1ns/1ps
module prcf_rx_filter (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic msg_valid_i,
  input wire logic [3:0] msg_kind_i,
  input wire logic [3:0] msg_version_i,
  input wire logic [7:0] msg_domain_i,
  input wire logic msg_alt_grandsource_i,
  input wire logic [15:0] msg_sequence_i,
  input wire logic [11:0] msg_source_crc_i,
  input wire logic [31:0] msg_sec_i,
  input wire logic [29:0] msg_ns_i,
  output logic filter_drop_o,
  output logic correction_modify_o
);
  prcf_cap_if cap ();

  prcf_capture_buffer u_buffer (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .cap(cap)
  );

  // Software state
  logic [15:0] correction_modify_type_mask, next_correction_modify_type_mask;
  logic [15:0] type_filter_mask, next_type_filter_mask;
  logic alternate_grandsource_filter_on, next_alternate_grandsource_filter_on;
  logic domain_filter_on, next_domain_filter_on;
  logic version_filter_on, next_version_filter_on;
  logic [3:0] version_ref, next_version_ref;
  logic [7:0] domain_ref, next_domain_ref;
  logic [3:0] pdreq_sec, next_pdreq_sec;
  logic [29:0] pdreq_ns, next_pdreq_ns;
  logic auto_update, next_auto_update;
  logic [2:0] bank_sel, next_bank_sel;
  // Bus state
  logic aw_have, next_aw_have, w_have, next_w_have;
  logic [11:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  // Message path
  logic next_filter_drop, next_correction_modify;
  logic drop_now, cf_hit, pdreq_hit, do_write, pop_req;

  // Word at an address; hit low means unmapped
  function automatic logic [32:0] read_word(input logic [11:0] addr);
    logic [31:0] w;
    logic hit;
    logic port_vis;
    w = 32'h0000_0000;
    hit = 1'b1;
    port_vis = (bank_sel == prcf_pkg::PORT_BANK);
    unique case (addr[11:2])
      prcf_pkg::OFS_CF_MOD[11:2]: w[15:0] = correction_modify_type_mask;
      prcf_pkg::OFS_FILTER[11:2]: begin
        w[15:0] = type_filter_mask;
        w[prcf_pkg::VER_FLT_BIT] = version_filter_on;
        w[prcf_pkg::DOM_FLT_BIT] = domain_filter_on;
        w[prcf_pkg::ALT_FLT_BIT] = alternate_grandsource_filter_on;
      end
      prcf_pkg::OFS_CAP_SEC[11:2]: w = cap.head.capture_whole_seconds;
      prcf_pkg::OFS_CAP_NS[11:2]: w[29:0] = cap.head.capture_nanos;
      prcf_pkg::OFS_CAP_HDR[11:2]: w = {cap.head.source_identity_crc,
        cap.head.message_kind_code, cap.head.sequence_number};
      prcf_pkg::OFS_PDREQ_SEC[11:2]: w[3:0] = pdreq_sec;
      prcf_pkg::OFS_PDREQ_NS[11:2]: begin
        w[29:0] = pdreq_ns;
        w[prcf_pkg::AUTO_UPDATE_BIT] = auto_update;
      end
      prcf_pkg::OFS_REFERENCE[11:2]: begin
        w[3:0] = version_ref;
        w[prcf_pkg::DOMAIN_REF_LSB +: 8] = domain_ref;
      end
      prcf_pkg::OFS_CAP_STATUS[11:2]: w[2:0] = cap.count;
      prcf_pkg::OFS_BANK_SEL[11:2]: begin
        w[2:0] = bank_sel;
        port_vis = 1'b1;
      end
      default: hit = 1'b0;
    endcase
    // Other banks hide this port's registers
    if (!port_vis) begin
      w = 32'h0000_0000;
    end
    return {hit, w};
  endfunction : read_word

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction : apply_strb

  // Filter and correction decisions
  always_comb begin
    drop_now = type_filter_mask[msg_kind_i];
    if (version_filter_on && (version_ref != prcf_pkg::VERSION_ANY)
        && (msg_version_i != version_ref)) begin
      drop_now = 1'b1;
    end
    if (domain_filter_on && (msg_domain_i != domain_ref)) begin
      drop_now = 1'b1;
    end
    if (alternate_grandsource_filter_on && msg_alt_grandsource_i) begin
      drop_now = 1'b1;
    end
    cf_hit = correction_modify_type_mask[msg_kind_i] && !drop_now;
    pdreq_hit = msg_valid_i && !drop_now && (msg_kind_i == prcf_pkg::KIND_PDELAY_REQ);
    next_filter_drop = msg_valid_i && drop_now;
    next_correction_modify = msg_valid_i && cf_hit;
  end

  assign cap.push = msg_valid_i && !drop_now;
  assign cap.push_entry = '{source_identity_crc: msg_source_crc_i,
    message_kind_code: msg_kind_i, sequence_number: msg_sequence_i,
    capture_whole_seconds: msg_sec_i, capture_nanos: msg_ns_i};
  assign do_write = aw_have && w_have && !s_axi_bvalid_o;
  assign pop_req = do_write && (bank_sel == prcf_pkg::PORT_BANK)
    && (aw_addr[11:2] == prcf_pkg::OFS_CAP_STATUS[11:2]) && w_strb[0] && w_data[prcf_pkg::POP_BIT];
  assign cap.pop = pop_req;

  // Bus and register next state
  always_comb begin
    logic [32:0] old;
    logic [31:0] nw;
    logic [32:0] rd;
    old = read_word(aw_addr);
    nw = apply_strb(old[31:0], w_data, w_strb);
    rd = read_word(s_axi_araddr_i);
    next_correction_modify_type_mask = correction_modify_type_mask;
    next_type_filter_mask = type_filter_mask;
    next_alternate_grandsource_filter_on = alternate_grandsource_filter_on;
    next_domain_filter_on = domain_filter_on;
    next_version_filter_on = version_filter_on;
    next_version_ref = version_ref;
    next_domain_ref = domain_ref;
    next_pdreq_sec = pdreq_sec;
    next_pdreq_ns = pdreq_ns;
    next_auto_update = auto_update;
    next_bank_sel = bank_sel;
    next_aw_have = aw_have || (s_axi_awvalid_i && s_axi_awready_o);
    next_w_have = w_have || (s_axi_wvalid_i && s_axi_wready_o);
    next_aw_addr = (s_axi_awvalid_i && s_axi_awready_o) ? s_axi_awaddr_i : aw_addr;
    next_w_data = (s_axi_wvalid_i && s_axi_wready_o) ? s_axi_wdata_i : w_data;
    next_w_strb = (s_axi_wvalid_i && s_axi_wready_o) ? s_axi_wstrb_i : w_strb;
    next_bvalid = s_axi_bvalid_o && !s_axi_bready_i;
    next_bresp = s_axi_bresp_o;
    if (do_write) begin
      next_aw_have = 1'b0;
      next_w_have = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = old[32] ? prcf_pkg::RESP_OKAY : prcf_pkg::RESP_SLVERR;
      if (aw_addr[11:2] == prcf_pkg::OFS_BANK_SEL[11:2]) begin
        next_bank_sel = nw[2:0];
      end else if (bank_sel == prcf_pkg::PORT_BANK) begin
        unique case (aw_addr[11:2])
          prcf_pkg::OFS_CF_MOD[11:2]: next_correction_modify_type_mask = nw[15:0];
          prcf_pkg::OFS_FILTER[11:2]: begin
            next_type_filter_mask = nw[15:0];
            next_version_filter_on = nw[prcf_pkg::VER_FLT_BIT];
            next_domain_filter_on = nw[prcf_pkg::DOM_FLT_BIT];
            next_alternate_grandsource_filter_on = nw[prcf_pkg::ALT_FLT_BIT];
          end
          prcf_pkg::OFS_PDREQ_SEC[11:2]: next_pdreq_sec = nw[3:0];
          prcf_pkg::OFS_PDREQ_NS[11:2]: begin
            next_pdreq_ns = nw[29:0];
            next_auto_update = nw[prcf_pkg::AUTO_UPDATE_BIT];
          end
          prcf_pkg::OFS_REFERENCE[11:2]: begin
            next_version_ref = nw[3:0];
            next_domain_ref = nw[prcf_pkg::DOMAIN_REF_LSB +: 8];
          end
          default: next_bank_sel = bank_sel;
        endcase
      end
    end
    if (pdreq_hit && auto_update) begin
      next_pdreq_sec = msg_sec_i[3:0];
      next_pdreq_ns = msg_ns_i;
    end
    next_awready = !next_aw_have && !next_bvalid;
    next_wready = !next_w_have && !next_bvalid;
    next_rvalid = s_axi_rvalid_o && !s_axi_rready_i;
    next_rdata = s_axi_rdata_o;
    next_rresp = s_axi_rresp_o;
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      next_rvalid = 1'b1;
      next_rdata = rd[31:0];
      next_rresp = rd[32] ? prcf_pkg::RESP_OKAY : prcf_pkg::RESP_SLVERR;
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      correction_modify_type_mask <= prcf_pkg::RST_CF_MOD;
      type_filter_mask <= prcf_pkg::RST_TYPE_FILTER;
      alternate_grandsource_filter_on <= 1'b0;
      domain_filter_on <= 1'b0;
      version_filter_on <= 1'b0;
      version_ref <= prcf_pkg::RST_VERSION_REF;
      domain_ref <= prcf_pkg::RST_DOMAIN_REF;
      pdreq_sec <= 4'h0;
      pdreq_ns <= 30'h0000_0000;
      auto_update <= 1'b0;
      bank_sel <= prcf_pkg::RST_BANK_SEL;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= prcf_pkg::RESP_OKAY;
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= prcf_pkg::RESP_OKAY;
      filter_drop_o <= 1'b0;
      correction_modify_o <= 1'b0;
    end else begin
      correction_modify_type_mask <= next_correction_modify_type_mask;
      type_filter_mask <= next_type_filter_mask;
      alternate_grandsource_filter_on <= next_alternate_grandsource_filter_on;
      domain_filter_on <= next_domain_filter_on;
      version_filter_on <= next_version_filter_on;
      version_ref <= next_version_ref;
      domain_ref <= next_domain_ref;
      pdreq_sec <= next_pdreq_sec;
      pdreq_ns <= next_pdreq_ns;
      auto_update <= next_auto_update;
      bank_sel <= next_bank_sel;
      aw_have <= next_aw_have;
      w_have <= next_w_have;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready_o <= next_awready;
      s_axi_wready_o <= next_wready;
      s_axi_bvalid_o <= next_bvalid;
      s_axi_bresp_o <= next_bresp;
      s_axi_arready_o <= next_arready;
      s_axi_rvalid_o <= next_rvalid;
      s_axi_rdata_o <= next_rdata;
      s_axi_rresp_o <= next_rresp;
      filter_drop_o <= next_filter_drop;
      correction_modify_o <= next_correction_modify;
    end
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence ar_taken;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  sequence ns_read;
    ar_taken and (s_axi_araddr_i[11:2] == prcf_pkg::OFS_CAP_NS[11:2]);
  endsequence

  AST_CF_GATE: assert property (msg_valid_i |=> correction_modify_o == $past(cf_hit))
    else $error("correction flag does not follow type mask");
  AST_ALT_DROP: assert property (
    msg_valid_i && alternate_grandsource_filter_on && msg_alt_grandsource_i |=> filter_drop_o)
    else $error("alternate flag message not filtered");
  AST_DOM_DROP: assert property (
    msg_valid_i && domain_filter_on && (msg_domain_i != domain_ref) |=> filter_drop_o)
    else $error("foreign domain message not filtered");
  AST_VER_DROP: assert property (
    msg_valid_i && version_filter_on && (version_ref != prcf_pkg::VERSION_ANY)
      && (msg_version_i != version_ref) |=> filter_drop_o)
    else $error("wrong version message not filtered");
  AST_TYPE_DROP: assert property (
    msg_valid_i && type_filter_mask[msg_kind_i] |=> filter_drop_o && !correction_modify_o)
    else $error("masked type not filtered");
  AST_CAP_GROW: assert property (
    cap.push && !cap.pop && (cap.count < prcf_pkg::CAP_FULL_COUNT)
      |=> cap.count == $past(cap.count) + 3'h1)
    else $error("capture not stored");
  AST_NS_RSVD: assert property (ns_read |=> s_axi_rvalid_o && (s_axi_rdata_o[31:30] == 2'b00))
    else $error("nanoseconds upper bits not zero");
  AST_PDREQ_AUTO: assert property (
    pdreq_hit && auto_update |=> pdreq_sec == $past(msg_sec_i[3:0]) && pdreq_ns == $past(msg_ns_i))
    else $error("peer-delay request time not updated");
  AST_PDREQ_HOLD: assert property (
    !auto_update && !do_write |=> $stable(pdreq_sec))
    else $error("peer-delay seconds changed without cause");
  AST_RD_ANSWER: assert property (ar_taken |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read not answered next cycle");
endmodule : prcf_rx_filter

// [testbench/prcf_msg_source.sv]
// Frame parser stand-in: one-cycle message pulses with their header fields
`timescale 1ns/1ps
module prcf_msg_source (
  input wire logic sys_clk_i,
  output logic msg_valid_o,
  output logic [3:0] msg_kind_o,
  output logic [3:0] msg_version_o,
  output logic [7:0] msg_domain_o,
  output logic msg_alt_o,
  output logic [15:0] msg_sequence_o,
  output logic [11:0] msg_crc_o,
  output logic [31:0] msg_sec_o,
  output logic [29:0] msg_ns_o
);
  logic [106:0] fields = '0;
  assign {msg_kind_o, msg_version_o, msg_domain_o, msg_alt_o} = fields[106:90];
  assign {msg_sequence_o, msg_crc_o, msg_sec_o, msg_ns_o} = fields[89:0];
  initial msg_valid_o = 1'b0;

  task automatic send(input logic [3:0] k, input logic [3:0] v, input logic [7:0] d,
                      input logic a, input logic [31:0] s, input logic [29:0] n);
    msg_valid_o <= 1'b1;
    fields <= {k, v, d, a, s[15:0], n[11:0], s, n};
    @(posedge sys_clk_i);
    msg_valid_o <= 1'b0;
    // Fields are not held past the pulse, so stale values cannot pass
    fields <= ~{k, v, d, a, s[15:0], n[11:0], s, n};
  endtask : send
endmodule : prcf_msg_source

// [testbench/prcf_rx_filter_tb.sv]
// Self-checking bench of the receive capture filter register bank
`timescale 1ns/1ps
module prcf_rx_filter_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, drop, modify;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic m_valid, m_alt;
  logic [3:0] m_kind, m_ver;
  logic [7:0] m_dom;
  logic [15:0] m_seq;
  logic [11:0] m_crc;
  logic [31:0] m_sec;
  logic [29:0] m_ns;
  int bad_count = 0;
  int total_checks = 0;

  always #50 sys_clk = ~sys_clk;

  prcf_rx_filter prcf_rx_filter_inst (
    .sys_clk_i(sys_clk), .rst_i(rst),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .msg_valid_i(m_valid), .msg_kind_i(m_kind), .msg_version_i(m_ver),
    .msg_domain_i(m_dom), .msg_alt_grandsource_i(m_alt), .msg_sequence_i(m_seq),
    .msg_source_crc_i(m_crc), .msg_sec_i(m_sec), .msg_ns_i(m_ns),
    .filter_drop_o(drop), .correction_modify_o(modify)
  );

  prcf_msg_source prcf_msg_source_inst (
    .sys_clk_i(sys_clk), .msg_valid_o(m_valid), .msg_kind_o(m_kind),
    .msg_version_o(m_ver), .msg_domain_o(m_dom), .msg_alt_o(m_alt),
    .msg_sequence_o(m_seq), .msg_crc_o(m_crc), .msg_sec_o(m_sec), .msg_ns_o(m_ns)
  );

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  task automatic chkb(input string w, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", w, e, g);
    end
  endtask : chkb

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0,
                    input logic [3:0] s = 4'hf);
    int n;
    logic [1:0] r;
    n = 0;
    r = 2'h3;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (r === 2'h3 && n < 100) begin
      @(posedge sys_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        r = bresp;
        bready <= 1'b0;
      end
    end
    // Idle edge, so a next call never re-drives a strobe in this step
    @(posedge sys_clk);
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string w,
                    input logic [1:0] er = 2'h0);
    int n;
    logic [1:0] r;
    logic [31:0] d;
    n = 0;
    r = 2'h3;
    d = 32'h0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (r === 2'h3 && n < 100) begin
      @(posedge sys_clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
    @(posedge sys_clk);
    chk(w, e, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask : rd

  // Both flags stand exactly one cycle after the message pulse
  task automatic msg(input logic [3:0] k, input logic [3:0] v, input logic [7:0] d,
                     input logic a, input logic [31:0] s, input logic [29:0] n,
                     input logic ed, input logic em);
    prcf_msg_source_inst.send(k, v, d, a, s, n);
    @(posedge sys_clk);
    chkb("drop", ed, drop);
    chkb("modify", em, modify);
    @(posedge sys_clk);
    chkb("drop end", 1'b0, drop);
    chkb("modify end", 1'b0, modify);
  endtask : msg

  task automatic test_reset();
    rd(prcf_pkg::OFS_CF_MOD, 32'h0, "unbanked");
    wr(prcf_pkg::OFS_BANK_SEL, 32'h1);
    rd(prcf_pkg::OFS_CF_MOD, 32'h0000000f, "cf mask");
    rd(prcf_pkg::OFS_FILTER, 32'h0, "filter");
    rd(prcf_pkg::OFS_CAP_SEC, 32'h0, "sec");
    rd(prcf_pkg::OFS_CAP_NS, 32'h0, "ns");
    rd(prcf_pkg::OFS_CAP_HDR, 32'h0, "hdr");
    rd(prcf_pkg::OFS_PDREQ_SEC, 32'h0, "pd sec");
    rd(prcf_pkg::OFS_REFERENCE, 32'h00000002, "reference");
    rd(prcf_pkg::OFS_CAP_STATUS, 32'h0, "count");
  endtask : test_reset

  task automatic test_access();
    wr(prcf_pkg::OFS_CF_MOD, 32'hffffffff);
    rd(prcf_pkg::OFS_CF_MOD, 32'h0000ffff, "cf mask");
    wr(prcf_pkg::OFS_CF_MOD, 32'h0, 2'h0, 4'h2);
    rd(prcf_pkg::OFS_CF_MOD, 32'h000000ff, "cf mask byte");
    wr(prcf_pkg::OFS_CAP_SEC, 32'hffffffff);
    rd(prcf_pkg::OFS_CAP_SEC, 32'h0, "ro sec");
    wr(prcf_pkg::OFS_PDREQ_SEC, 32'hffffffff);
    rd(prcf_pkg::OFS_PDREQ_SEC, 32'h0000000f, "pd sec");
    wr(12'h1f0, 32'h1, 2'h2);
    rd(12'h1f0, 32'h0, "unmapped", 2'h2);
  endtask : test_access

  // Fifth message meets a full buffer; the four oldest must survive
  task automatic test_capture();
    for (int i = 0; i < 5; i++)
      msg(i[3:0], 4'h2, 8'h00, 1'b0, {28'hc0de000, i[3:0]}, {6'h3c, 20'habcde, i[3:0]},
          1'b0, 1'b1);
    rd(prcf_pkg::OFS_CAP_STATUS, 32'h4, "count");
    for (int i = 0; i < 4; i++) begin
      rd(prcf_pkg::OFS_CAP_SEC, {28'hc0de000, i[3:0]}, "sec");
      rd(prcf_pkg::OFS_CAP_NS, {8'h3c, 20'habcde, i[3:0]}, "ns");
      rd(prcf_pkg::OFS_CAP_HDR, {8'hde, i[3:0], i[3:0], 12'h0, i[3:0]}, "hdr");
      wr(prcf_pkg::OFS_CAP_STATUS, 32'h1);
    end
    rd(prcf_pkg::OFS_CAP_STATUS, 32'h0, "count");
  endtask : test_capture

  task automatic test_kinds();
    logic [15:0] cf;
    logic [15:0] ft;
    cf = 16'h8421;
    ft = 16'h4202;
    wr(prcf_pkg::OFS_CF_MOD, {16'h0, cf});
    wr(prcf_pkg::OFS_FILTER, {16'h0, ft});
    for (int k = 0; k < 16; k++)
      msg(k[3:0], 4'h2, 8'h00, 1'b0, 32'h0, 30'h0, ft[k], cf[k] & !ft[k]);
  endtask : test_kinds

  // Rows: enable bits 18:16, version, domain, flag; reference stays 2 and 0
  task automatic test_fields();
    logic [2:0] c[7] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
    logic [3:0] v[7] = '{4'h3, 4'h2, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3};
    logic [7:0] d[7] = '{8'h05, 8'h05, 8'h05, 8'h00, 8'h05, 8'h05, 8'h05};
    logic [6:0] al = 7'b1000001;
    logic [6:0] dr = 7'b1010100;
    for (int i = 0; i < 7; i++) begin
      wr(prcf_pkg::OFS_FILTER, {13'h0, c[i], 16'h0});
      msg(4'h0, v[i], d[i], al[i], 32'h0, 30'h0, dr[i], !dr[i]);
    end
    // Version reference zero accepts any version; domain reference moved to 5
    wr(prcf_pkg::OFS_REFERENCE, 32'h00000500);
    wr(prcf_pkg::OFS_FILTER, 32'h00030000);
    msg(4'h0, 4'h7, 8'h05, 1'b0, 32'h0, 30'h0, 1'b0, 1'b1);
    msg(4'h0, 4'h7, 8'h04, 1'b0, 32'h0, 30'h0, 1'b1, 1'b0);
    wr(prcf_pkg::OFS_FILTER, 32'h0);
  endtask : test_fields

  task automatic test_auto();
    wr(prcf_pkg::OFS_PDREQ_NS, 32'h80000000);
    msg(4'h2, 4'h2, 8'h00, 1'b0, 32'h12345679, 30'h0abcdef0, 1'b0, 1'b0);
    rd(prcf_pkg::OFS_PDREQ_SEC, 32'h9, "pd sec");
    rd(prcf_pkg::OFS_PDREQ_NS, 32'h8abcdef0, "pd ns");
    wr(prcf_pkg::OFS_PDREQ_NS, 32'h0);
    msg(4'h2, 4'h2, 8'h00, 1'b0, 32'h3, 30'h5, 1'b0, 1'b0);
    rd(prcf_pkg::OFS_PDREQ_SEC, 32'h9, "pd kept");
    wr(prcf_pkg::OFS_PDREQ_SEC, 32'hfffffff5);
    rd(prcf_pkg::OFS_PDREQ_SEC, 32'h5, "pd sw");
  endtask : test_auto

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    test_reset();
    test_access();
    test_capture();
    test_kinds();
    test_fields();
    test_auto();
    give_verdict();
  end

  // Roughly twenty times the expected run length
  initial begin
    repeat (6000) @(posedge sys_clk);
    bad_count++;
    give_verdict();
  end
endmodule : prcf_rx_filter_tb
